// [hdl/uart_multidrop.sv]
// serial port with address filtering, shared data port, axi4-lite slave
// Overview of operation
// - filtering on drops frames without address mark
// - transmitter ignores the filtering enable
// - five to eight bits: stop bit marks type
// - nine bits: ninth data bit marks type
// - type one is address, zero is data
// - ninth bit sent exactly as software set
// - accepted address frames buffered and flagged normally
// - one data address: write transmits, read receives
// - unused upper bits dropped and read zero
// - data write ignored while buffer not empty
// - buffered byte moves to idle shifter, sent
// - two-entry receive fifo advances per data read
// - sixteen or eight samples per bit
// - vote at samples 8-10 or 4-6
// - normal speed tolerates 95.36 to 104.58 percent
// - double speed tolerates 96.00 to 103.90 percent
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module uart_multidrop (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// axi4-lite write address
	input  wire logic [4:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	// axi4-lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read address
	input  wire logic [4:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	// axi4-lite read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// serial line
	input  wire logic        rxd,
	output logic             txd
);
	// register index codes returned by the decoder
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_A    = 3'h1;
	localparam logic [2:0] IDX_B    = 3'h2;
	localparam logic [2:0] IDX_C    = 3'h3;
	localparam logic [2:0] IDX_BAUD = 3'h4;
	localparam logic [2:0] IDX_NONE = 3'h7;

	// address decode, shared by read and write paths
	function automatic logic [2:0] reg_index(input logic [4:0] addr);
		if (addr == uart_pkg::ADDR_DATA)
			reg_index = IDX_DATA;
		else if (addr == uart_pkg::ADDR_STAT_A)
			reg_index = IDX_A;
		else if (addr == uart_pkg::ADDR_CTRL_B)
			reg_index = IDX_B;
		else if (addr == uart_pkg::ADDR_CTRL_C)
			reg_index = IDX_C;
		else if (addr == uart_pkg::ADDR_BAUD)
			reg_index = IDX_BAUD;
		else
			reg_index = IDX_NONE;
	endfunction : reg_index

	// bus slave state
	logic [4:0]  aw_addr_q, next_aw_addr;    // held write address
	logic [31:0] w_data_q, next_w_data;      // held write data
	logic [3:0]  w_strb_q, next_w_strb;      // held byte enables
	logic        next_awready, next_wready;
	logic        next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	// control bits
	logic        filter_en, next_filter;     // frame_filter_enable
	logic        dbl, next_dbl;              // double_speed_select
	logic        rx_en, next_rx_en;
	logic        tx_en, next_tx_en;
	logic [2:0]  size_code, next_size;       // char_size_field
	logic        tx_ninth, next_tx_ninth;
	logic        par_en, next_par_en;
	logic        par_odd, next_par_odd;
	logic        two_stop, next_two_stop;    // stop_bit_count_select
	logic [11:0] baud_div, next_baud;        // baud_divisor
	// transmit holding buffer
	logic [8:0]  tx_hold, next_tx_hold;
	logic        tx_empty, next_tx_empty;    // tx_buffer_empty_flag
	logic        tx_cmpl, next_tx_cmpl;      // tx_complete_flag
	// receive fifo, two entries of {perr, ferr, data9}
	logic [10:0] fifo_mem [2];
	logic [10:0] next_mem [2];
	logic        rd_ptr, next_rd_ptr;
	logic [1:0]  count, next_count;
	logic        overrun, next_overrun;
	// sample tick generator
	logic [11:0] baud_cnt, next_baud_cnt;
	logic        tick, next_tick;
	// links to the shifters
	logic        tx_load, tx_idle, tx_done;
	logic        rx_done, rx_type, rx_ferr, rx_perr;
	logic [8:0]  rx_data;
	// combinational helpers
	logic        do_write, do_read;
	logic [2:0]  w_idx, r_idx;
	logic [10:0] head;
	logic [1:0]  cnt_tmp;
	logic        ptr_tmp;

	assign head = fifo_mem[rd_ptr];
	// buffered byte goes to the shifter once it is free
	assign tx_load = !tx_empty && tx_en && tx_idle;

	// receive sampler
	uart_rx_sampler u_rx (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.sample_tick  (tick),
		.rxd_pin      (rxd),
		.enable       (rx_en),
		.double_speed (dbl),
		.size_code    (size_code),
		.parity_en    (par_en),
		.parity_odd   (par_odd),
		.frame_done   (rx_done),
		.frame_data   (rx_data),
		.frame_type   (rx_type),
		.frame_err    (rx_ferr),
		.parity_err   (rx_perr)
	);

	// transmit shifter, filtering enable deliberately not wired
	uart_tx_shifter u_tx (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.sample_tick  (tick),
		.double_speed (dbl),
		.size_code    (size_code),
		.parity_en    (par_en),
		.parity_odd   (par_odd),
		.two_stop     (two_stop),
		.load         (tx_load),
		.load_data    (tx_hold),
		.idle         (tx_idle),
		.done         (tx_done),
		.txd          (txd)
	);

	// next values for bus, control, buffers and tick
	always_comb
	begin
		next_aw_addr = aw_addr_q;
		next_w_data = w_data_q;
		next_w_strb = w_strb_q;
		next_awready = awready;
		next_wready = wready;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_arready = arready;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		next_filter = filter_en;
		next_dbl = dbl;
		next_rx_en = rx_en;
		next_tx_en = tx_en;
		next_size = size_code;
		next_tx_ninth = tx_ninth;
		next_par_en = par_en;
		next_par_odd = par_odd;
		next_two_stop = two_stop;
		next_baud = baud_div;
		next_tx_hold = tx_hold;
		next_tx_empty = tx_empty;
		next_tx_cmpl = tx_cmpl;
		next_mem = fifo_mem;
		next_rd_ptr = rd_ptr;
		next_count = count;
		next_overrun = overrun;
		// sample tick from the divisor
		next_tick = (baud_cnt == 12'h000);
		next_baud_cnt = next_tick ? baud_div : baud_cnt - 12'h001;

		// address and data accepted independently, either order
		if (awvalid && awready)
		begin
			next_aw_addr = awaddr;
			next_awready = 1'b0;
		end
		if (wvalid && wready)
		begin
			next_w_data = wdata;
			next_w_strb = wstrb;
			next_wready = 1'b0;
		end
		if (bvalid && bready)
			next_bvalid = 1'b0;
		do_write = !awready && !wready && !bvalid;
		w_idx = reg_index(aw_addr_q);
		do_read = arvalid && arready;
		r_idx = reg_index(araddr);

		// shifter took the held byte
		if (tx_load)
			next_tx_empty = 1'b1;
		// complete when the frame left and nothing waits
		if (tx_done && tx_empty)
			next_tx_cmpl = 1'b1;

		if (do_write)
		begin
			next_awready = 1'b1;
			next_wready = 1'b1;
			next_bvalid = 1'b1;
			next_bresp = (w_idx == IDX_NONE) ? uart_pkg::RESP_SLVERR : uart_pkg::RESP_OKAY;
			if (w_strb_q[0])
			begin
				if (w_idx == IDX_DATA)
				begin
					// write lands only while the buffer is empty
					if (tx_empty)
					begin
						next_tx_hold = {tx_ninth, w_data_q[7:0]};
						next_tx_empty = 1'b0;
					end
				end
				else if (w_idx == IDX_A)
				begin
					next_filter = w_data_q[uart_pkg::A_FILTER];
					next_dbl = w_data_q[uart_pkg::A_DBL];
					// write one clears, a same-cycle completion wins
					if (w_data_q[uart_pkg::A_TX_DONE] && !(tx_done && tx_empty))
						next_tx_cmpl = 1'b0;
				end
				else if (w_idx == IDX_B)
				begin
					next_rx_en = w_data_q[uart_pkg::B_RX_EN];
					next_tx_en = w_data_q[uart_pkg::B_TX_EN];
					next_size[2] = w_data_q[uart_pkg::B_SIZE2];
					next_tx_ninth = w_data_q[uart_pkg::B_TX9];
				end
				else if (w_idx == IDX_C)
				begin
					next_par_en = w_data_q[uart_pkg::C_PAR_EN];
					next_par_odd = w_data_q[uart_pkg::C_PAR_ODD];
					next_two_stop = w_data_q[uart_pkg::C_STOP2];
					next_size[1:0] = w_data_q[uart_pkg::C_SIZE_LO +: 2];
				end
				else if (w_idx == IDX_BAUD)
					next_baud[7:0] = w_data_q[7:0];
			end
			if (w_strb_q[1] && w_idx == IDX_BAUD)
				next_baud[11:8] = w_data_q[11:8];
		end

		// read: register the answer, data port pops the fifo
		if (rvalid && rready)
		begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		cnt_tmp = count;
		ptr_tmp = rd_ptr;
		if (do_read)
		begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = uart_pkg::RESP_OKAY;
			next_rdata = 32'h0000_0000;
			if (r_idx == IDX_DATA)
			begin
				next_rdata[7:0] = head[7:0];
				// every data read with an entry waiting moves the fifo
				if (count != 2'h0)
				begin
					cnt_tmp = count - 2'h1;
					ptr_tmp = ~rd_ptr;
				end
			end
			else if (r_idx == IDX_A)
				next_rdata[7:0] = {count != 2'h0, tx_cmpl, tx_empty,
					head[9] & (count != 2'h0), overrun,
					head[10] & (count != 2'h0), dbl, filter_en};
			else if (r_idx == IDX_B)
				next_rdata[7:0] = {3'h0, rx_en, tx_en, size_code[2],
					head[8] & (count != 2'h0), tx_ninth};
			else if (r_idx == IDX_C)
				next_rdata[7:0] = {2'h0, par_en, par_odd, two_stop,
					size_code[1:0], 1'b0};
			else if (r_idx == IDX_BAUD)
				next_rdata[11:0] = baud_div;
			else
				next_rresp = uart_pkg::RESP_SLVERR;
		end

		// filtering drops data frames silently
		if (rx_done && rx_en && !(filter_en && !rx_type))
		begin
			if (cnt_tmp == 2'h2)
				next_overrun = 1'b1;
			else
			begin
				// stored and flagged like any frame
				next_mem[ptr_tmp ^ cnt_tmp[0]] = {rx_perr, rx_ferr, rx_data};
				cnt_tmp = cnt_tmp + 2'h1;
				next_overrun = 1'b0;
			end
		end
		next_count = cnt_tmp;
		next_rd_ptr = ptr_tmp;
		// disabled receiver flushes the fifo
		if (!rx_en)
		begin
			next_count = 2'h0;
			next_overrun = 1'b0;
		end
	end

	// registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			aw_addr_q <= 5'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= uart_pkg::RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rresp <= uart_pkg::RESP_OKAY;
			rdata <= 32'h0000_0000;
			filter_en <= 1'b0;
			dbl <= 1'b0;
			rx_en <= 1'b0;
			tx_en <= 1'b0;
			size_code <= uart_pkg::SIZE_RESET;
			tx_ninth <= 1'b0;
			par_en <= 1'b0;
			par_odd <= 1'b0;
			two_stop <= 1'b0;
			baud_div <= uart_pkg::BAUD_RESET;
			tx_hold <= 9'h000;
			tx_empty <= 1'b1;
			tx_cmpl <= 1'b0;
			fifo_mem[0] <= 11'h000;
			fifo_mem[1] <= 11'h000;
			rd_ptr <= 1'b0;
			count <= 2'h0;
			overrun <= 1'b0;
			baud_cnt <= 12'h000;
			tick <= 1'b0;
		end
		else
		begin
			aw_addr_q <= next_aw_addr;
			w_data_q <= next_w_data;
			w_strb_q <= next_w_strb;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			filter_en <= next_filter;
			dbl <= next_dbl;
			rx_en <= next_rx_en;
			tx_en <= next_tx_en;
			size_code <= next_size;
			tx_ninth <= next_tx_ninth;
			par_en <= next_par_en;
			par_odd <= next_par_odd;
			two_stop <= next_two_stop;
			baud_div <= next_baud;
			tx_hold <= next_tx_hold;
			tx_empty <= next_tx_empty;
			tx_cmpl <= next_tx_cmpl;
			fifo_mem <= next_mem;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			overrun <= next_overrun;
			baud_cnt <= next_baud_cnt;
			tick <= next_tick;
		end
	end
endmodule : uart_multidrop
`default_nettype wire

// [hdl/uart_pkg.sv]
// shared constants for the multidrop serial port
package uart_pkg;
	// register byte addresses
	localparam logic [4:0] ADDR_DATA   = 5'h00;
	localparam logic [4:0] ADDR_STAT_A = 5'h04;
	localparam logic [4:0] ADDR_CTRL_B = 5'h08;
	localparam logic [4:0] ADDR_CTRL_C = 5'h0c;
	localparam logic [4:0] ADDR_BAUD   = 5'h10;
	// ctrl_status_a bit positions
	localparam int A_RX_DONE  = 7;
	localparam int A_TX_DONE  = 6;
	localparam int A_TX_EMPTY = 5;
	localparam int A_FRM_ERR  = 4;
	localparam int A_OVERRUN  = 3;
	localparam int A_PAR_ERR  = 2;
	localparam int A_DBL      = 1;
	localparam int A_FILTER   = 0;
	// ctrl_b bit positions
	localparam int B_RX_EN = 4;
	localparam int B_TX_EN = 3;
	localparam int B_SIZE2 = 2;
	localparam int B_RX9   = 1;
	localparam int B_TX9   = 0;
	// ctrl_c bit positions
	localparam int C_PAR_EN  = 5;
	localparam int C_PAR_ODD = 4;
	localparam int C_STOP2   = 3;
	localparam int C_SIZE_LO = 1;
	// sampling figures
	localparam logic [4:0] SAMPLES_NORMAL    = 5'h10;
	localparam logic [4:0] SAMPLES_DOUBLE    = 5'h08;
	localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
	// size code for nine-bit characters
	localparam logic [2:0] SIZE_NINE = 3'h7;
	// reset values
	localparam logic [11:0] BAUD_RESET = 12'h000;
	localparam logic [2:0]  SIZE_RESET = 3'h3;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// data bits for a size code, reserved codes act as eight
	function automatic logic [3:0] char_bits(input logic [2:0] code);
		if (code == SIZE_NINE)
			char_bits = 4'h9;
		else if (code[2])
			char_bits = 4'h8;
		else
			char_bits = 4'h5 + {2'h0, code[1:0]};
	endfunction : char_bits
endpackage : uart_pkg

// [hdl/uart_rx_sampler.sv]
// receive sampler: start detect, majority vote, frame assembly
`timescale 1ns/1ns
`default_nettype none
module uart_rx_sampler (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// sample tick and line
	input  wire logic       sample_tick,
	input  wire logic       rxd_pin,
	// format
	input  wire logic       enable,
	input  wire logic       double_speed,
	input  wire logic [2:0] size_code,
	input  wire logic       parity_en,
	input  wire logic       parity_odd,
	// finished frame
	output logic            frame_done,
	output logic [8:0]      frame_data,
	output logic            frame_type,
	output logic            frame_err,
	output logic            parity_err
);
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_START = 3'b010,
		RX_BITS  = 3'b100
	} rx_state_t;

	logic       rxd_meta, rxd_sync;         // line synchroniser
	rx_state_t  state, next_state;          // sequencer
	logic [4:0] sample_no, next_sample;     // sample within bit
	logic [1:0] votes, next_votes;          // first two vote samples
	logic [3:0] bit_idx, next_bit;          // bit within frame
	logic [10:0] shreg, next_shreg;         // collected bits, lsb first
	logic       next_done;
	logic [3:0] nb, last;                   // data bits, stop index
	logic [4:0] spb, sf, cur;
	logic       maj;

	// sequencing per sample tick
	always_comb
	begin
		nb = uart_pkg::char_bits(size_code);
		spb = double_speed ? uart_pkg::SAMPLES_DOUBLE : uart_pkg::SAMPLES_NORMAL;
		sf = double_speed ? uart_pkg::VOTE_FIRST_DOUBLE : uart_pkg::VOTE_FIRST_NORMAL;
		last = nb + {3'h0, parity_en};
		cur = sample_no + 5'h01;
		maj = (votes[1] & votes[0]) | (votes[1] & rxd_sync) | (votes[0] & rxd_sync);
		next_state = state;
		next_sample = sample_no;
		next_votes = votes;
		next_bit = bit_idx;
		next_shreg = shreg;
		next_done = 1'b0;
		if (!enable)
			next_state = RX_IDLE;
		else if (sample_tick)
		begin
			case (state)
				RX_IDLE:
				begin
					// first low sample counts as sample one
					if (!rxd_sync)
					begin
						next_state = RX_START;
						next_sample = 5'h01;
					end
				end
				RX_START, RX_BITS:
				begin
					next_sample = cur;
					if (cur == sf || cur == sf + 5'h01)
						next_votes = {votes[0], rxd_sync};
					// third vote sample decides the bit
					if (cur == sf + 5'h02)
					begin
						if (state == RX_START)
						begin
							if (maj)
								next_state = RX_IDLE; // noise spike
						end
						else
						begin
							next_shreg[bit_idx] = maj;
							// done right after the stop vote, early start allowed
							if (bit_idx == last)
							begin
								next_state = RX_IDLE;
								next_done = 1'b1;
							end
						end
					end
					if (cur == spb)
					begin
						next_sample = 5'h00;
						if (state == RX_START)
						begin
							next_state = RX_BITS;
							next_bit = 4'h0;
						end
						else
							next_bit = bit_idx + 4'h1;
					end
				end
				default: next_state = RX_IDLE;
			endcase
		end
	end

	// registers
	always_ff @(posedge sys_clk)
	begin
		rxd_meta <= rxd_pin;
		rxd_sync <= rxd_meta;
		if (rst)
		begin
			state <= RX_IDLE;
			sample_no <= 5'h00;
			votes <= 2'h3;
			bit_idx <= 4'h0;
			shreg <= 11'h7ff;
			frame_done <= 1'b0;
		end
		else
		begin
			state <= next_state;
			sample_no <= next_sample;
			votes <= next_votes;
			bit_idx <= next_bit;
			shreg <= next_shreg;
			frame_done <= next_done;
		end
	end

	// fields of the finished frame
	always_comb
	begin
		for (int i = 0; i < 9; i++)
			frame_data[i] = (i < int'(nb)) ? shreg[i] : 1'b0;
		// ninth bit or first stop bit marks the frame type
		frame_type = (nb == 4'h9) ? shreg[8] : shreg[last];
		frame_err = !shreg[last];
		parity_err = parity_en & ((^frame_data) ^ parity_odd ^ shreg[nb]);
	end
endmodule : uart_rx_sampler
`default_nettype wire

// [hdl/uart_tx_shifter.sv]
// transmit shift register and frame builder
`timescale 1ns/1ns
`default_nettype none
module uart_tx_shifter (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// tick and format
	input  wire logic       sample_tick,
	input  wire logic       double_speed,
	input  wire logic [2:0] size_code,
	input  wire logic       parity_en,
	input  wire logic       parity_odd,
	input  wire logic       two_stop,
	// load from holding buffer
	input  wire logic       load,
	input  wire logic [8:0] load_data,
	// status and line
	output logic            idle,
	output logic            done,
	output logic            txd
);
	logic [12:0] shreg, next_shreg;   // frame bits, lsb leaves first
	logic [3:0]  left, next_left;     // bits still to send
	logic [4:0]  ticks, next_ticks;   // ticks inside current bit
	logic        next_done, next_txd;
	logic [3:0]  nb;
	logic [4:0]  spb;

	// frame build and shifting
	always_comb
	begin
		nb = uart_pkg::char_bits(size_code);
		spb = double_speed ? uart_pkg::SAMPLES_DOUBLE : uart_pkg::SAMPLES_NORMAL;
		next_shreg = shreg;
		next_left = left;
		next_ticks = ticks;
		next_done = 1'b0;
		if (load && left == 4'h0)
		begin
			// start, data (upper unused dropped), parity, stops
			next_shreg = 13'h1ffe;
			for (int i = 0; i < 9; i++)
				if (i < int'(nb))
					next_shreg[i + 1] = load_data[i];
			if (parity_en)
				next_shreg[nb + 4'h1] = (^(load_data & ~(9'h1ff << nb))) ^ parity_odd;
			next_left = nb + 4'h2 + {3'h0, parity_en} + {3'h0, two_stop};
			next_ticks = 5'h00;
		end
		else if (left != 4'h0 && sample_tick)
		begin
			next_ticks = ticks + 5'h01;
			if (next_ticks == spb)
			begin
				next_ticks = 5'h00;
				next_shreg = {1'b1, shreg[12:1]};
				next_left = left - 4'h1;
				next_done = (left == 4'h1);
			end
		end
		next_txd = (next_left == 4'h0) ? 1'b1 : next_shreg[0];
	end

	// registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			shreg <= 13'h1fff;
			left <= 4'h0;
			ticks <= 5'h00;
			done <= 1'b0;
			txd <= 1'b1;
		end
		else
		begin
			shreg <= next_shreg;
			left <= next_left;
			ticks <= next_ticks;
			done <= next_done;
			txd <= next_txd;
		end
	end

	assign idle = (left == 4'h0);
endmodule : uart_tx_shifter
`default_nettype wire

// [verification/uart_multidrop_bench.sv]
// self-checking bench for the multidrop serial port
`timescale 1ns/1ns
`default_nettype none
module uart_multidrop_bench;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  awaddr = 5'h00;
	logic [4:0]  araddr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h1;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	wire logic   awready, wready, bvalid, arready, rvalid, rxd, txd;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	logic [3:0]  n = 4'h8;
	wire logic [9:0] got;
	int          got_n;
	int          failures = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [31:0] rq[$];
	logic [9:0]  tq[$];
	logic [31:0] seed = 32'h42d75d63;
	logic [7:0]  d[10];
	uart_multidrop i_dut (.*);
	uart_peer i_peer (.rxd(rxd), .txd(txd), .n(n), .got(got), .got_n(got_n));
	always #2 sys_clk = ~sys_clk;
	// hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			close_out();
		end
	end
	function automatic logic [7:0] nx();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : nx
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// result watchers take the oldest note
	always @(posedge sys_clk)
		if (rvalid && rready)
			chk("rdata", rq.pop_front(), rdata);
	always @(got_n)
		chk("txd frame", {22'h0, tq.pop_front()}, {22'h0, got});
	task wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge sys_clk); while (!bvalid);
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [4:0] a, input logic [31:0] e);
		rq.push_back(e);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (!rvalid);
		rready <= 1'b0;
	endtask : rd
	task txw();
		while (tq.size() != 0)
			@(posedge sys_clk);
	endtask : txw
	task close_out();
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	initial
	begin
		foreach (d[i])
			d[i] = nx();
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		// reset values and unmapped place
		rd(uart_pkg::ADDR_STAT_A, 32'h20);
		rd(uart_pkg::ADDR_CTRL_B, 32'h0);
		rd(uart_pkg::ADDR_CTRL_C, 32'h6);
		rd(5'h14, 32'h0);
		wr(5'h14, 32'hff);
		// third write lands on a full buffer
		wr(uart_pkg::ADDR_CTRL_B, 32'h18);
		tq.push_back({2'b01, d[0]});
		tq.push_back({2'b01, d[1]});
		wr(uart_pkg::ADDR_DATA, {24'h0, d[0]});
		wr(uart_pkg::ADDR_DATA, {24'h0, d[1]});
		wr(uart_pkg::ADDR_DATA, {24'h0, d[2]});
		txw();
		// nine-bit transmit with filtering on
		wr(uart_pkg::ADDR_STAT_A, 32'h01);
		wr(uart_pkg::ADDR_CTRL_B, 32'h1d);
		n <= 4'h9;
		tq.push_back({2'b11, d[3]});
		tq.push_back({2'b10, d[4]});
		wr(uart_pkg::ADDR_DATA, {24'h0, d[3]});
		wr(uart_pkg::ADDR_CTRL_B, 32'h1c);
		wr(uart_pkg::ADDR_DATA, {24'h0, d[4]});
		txw();
		// nine-bit receive, data frame dropped
		i_peer.send({2'b00, d[5]}, 9, 64.0);
		i_peer.send({2'b01, d[6]}, 9, 66.0);
		rd(uart_pkg::ADDR_STAT_A, 32'he1);
		rd(uart_pkg::ADDR_CTRL_B, 32'h1e);
		rd(uart_pkg::ADDR_DATA, {24'h0, d[6]});
		// eight-bit, stop bit as type, rate edges
		wr(uart_pkg::ADDR_CTRL_B, 32'h18);
		i_peer.send({2'b00, d[5]}, 9, 64.0);
		i_peer.send({2'b01, d[7]}, 9, 66.5);
		i_peer.send({2'b01, d[8]}, 9, 61.7);
		i_peer.send({2'b01, d[9]}, 9, 64.0);
		rd(uart_pkg::ADDR_DATA, {24'h0, d[7]});
		rd(uart_pkg::ADDR_DATA, {24'h0, d[8]});
		rd(uart_pkg::ADDR_STAT_A, 32'h69);
		// double speed, filtering off
		wr(uart_pkg::ADDR_STAT_A, 32'h02);
		i_peer.send({2'b01, d[9]}, 9, 33.0);
		i_peer.send({2'b01, d[2]}, 9, 31.0);
		rd(uart_pkg::ADDR_DATA, {24'h0, d[9]});
		rd(uart_pkg::ADDR_DATA, {24'h0, d[2]});
		// tx complete cleared by one, then five-bit even parity both ways
		wr(uart_pkg::ADDR_STAT_A, 32'h40);
		rd(uart_pkg::ADDR_STAT_A, 32'h20);
		wr(uart_pkg::ADDR_CTRL_C, 32'h20);
		i_peer.send({4'h1, ~^d[5][4:0], d[5][4:0]}, 7, 64.0);
		rd(uart_pkg::ADDR_STAT_A, 32'ha4);
		rd(uart_pkg::ADDR_DATA, {27'h0, d[5][4:0]});
		n <= 4'h5;
		tq.push_back({4'h0, ^d[8][4:0], d[8][4:0]});
		wr(uart_pkg::ADDR_DATA, {24'h0, d[8]});
		txw();
		repeat (4) @(posedge sys_clk);
		close_out();
	end
endmodule : uart_multidrop_bench
bind uart_multidrop uart_multidrop_monitor i_mon (.*);
`default_nettype wire

// [verification/uart_multidrop_monitor.sv]
// bus and line assertions for the multidrop serial port
`timescale 1ns/1ns
`default_nettype none
module uart_multidrop_monitor (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// register bus
	input wire logic [4:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [4:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	// serial line
	input wire logic        txd
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// both write halves taken, read address taken
	wire wr_go = awvalid && awready && wvalid && wready;
	wire rd_go = arvalid && arready;
	property p_wr_lat; wr_go |-> ##1 !bvalid ##1 bvalid; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer off time");
	property p_wr_busy; wr_go |=> !awready && !wready; endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("write ready not dropped");
	property p_wr_err; wr_go && awaddr > 5'h10 |-> ##2 bresp == uart_pkg::RESP_SLVERR; endproperty
	a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_rd_lat; rd_go |=> rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_rd_err; rd_go && araddr > 5'h10 |=> rresp == uart_pkg::RESP_SLVERR && rdata == 32'h0; endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
	property p_rd_data; rd_go && araddr == uart_pkg::ADDR_DATA |=> rdata[31:8] == 24'h0; endproperty
	a_rd_data: assert property (p_rd_data) else $error("data port upper bits set");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_start; $fell(txd) |-> !txd [*8]; endproperty
	a_start: assert property (p_start) else $error("start bit too short");
	property p_idle; $fell(rst) |-> txd; endproperty
	a_idle: assert property (p_idle) else $error("line not idle after reset");
endmodule : uart_multidrop_monitor
`default_nettype wire

// [verification/uart_peer.sv]
// far-end serial port: drives frames onto rxd, decodes frames from txd
`timescale 1ns/1ns
`default_nettype none
module uart_peer (
	// serial line
	output logic            rxd,
	input  wire logic       txd,
	// decode width and result
	input  wire logic [3:0] n,
	output logic [9:0]      got,
	output int              got_n
);
	initial
	begin
		rxd = 1'b1;
		got = 10'h000;
		got_n = 0;
	end
	// start, k bits lsb first (type bit last), then idle high
	task send(input logic [9:0] v, input int k, input realtime p);
		// step off the clock edge before the start bit
		#1;
		rxd = 1'b0;
		#p;
		for (int i = 0; i < k; i++)
		begin
			rxd = v[i];
			#p;
		end
		rxd = 1'b1;
		#(2 * p);
	endtask : send
	// mid-bit sampling of n data bits and the bit after them (first stop, or parity), normal speed
	always @(negedge txd)
	begin
		logic [9:0] w;
		w = 10'h000;
		#32;
		for (int i = 0; i <= n; i++)
		begin
			#64;
			w[i] = txd;
		end
		got = w;
		// let the word settle before announcing it
		#1;
		got_n++;
	end
endmodule : uart_peer
`default_nettype wire
